//--- hw/ccd_readout_seq.sv
/*
  Readout sequencer for a four-amplifier full-frame sensor: cleaning,
  parallel row shift (row pairs in four-port mode), serial shift to four nodes or one factory
  node, region-of-interest discard, and cooler readback/lock status.
  Assumes converter results arrive on adc_data in the cycle a pixel is
  emptied into its node; all inputs except arst_n synchronous to clk.
*/
//
// Overview of operation
// - start readout: shift both halves toward registers
// - row pair loaded: clock charge to nodes
// - digitize each pixel as it empties
// - next row pair only after all digitized
// - full resolution: one sample per pixel
// - four-port for full or centered symmetric region
// - single-port when region not centered symmetric
// - same choice with or without binning
// - single-port node fixed at manufacture
// - clock out and drop pixels outside region
// - ready for next exposure right after readout
// - report cooling-block temperature on request
// - lock flag clears on overshoot, resets
// - after readout, resume continuous cleaning
`timescale 1ns/1ns
module ccd_readout_seq #(
  parameter int         COLS        = ccd_seq_pkg::COLS,
  parameter int         ROWS        = ccd_seq_pkg::ROWS,
  parameter logic [1:0] SINGLE_PORT = ccd_seq_pkg::SINGLE_PORT_DEFAULT
) (
  input  wire logic                                  clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  exposure_end,
  input  wire logic                                  full_frame,
  input  wire logic                                  binning_en,
  input  wire logic [ccd_seq_pkg::COORD_W-1:0]       roi_x_start,
  input  wire logic [ccd_seq_pkg::COORD_W-1:0]       roi_x_end,
  input  wire logic [ccd_seq_pkg::COORD_W-1:0]       roi_y_start,
  input  wire logic [ccd_seq_pkg::COORD_W-1:0]       roi_y_end,
  input  wire logic [4*ccd_seq_pkg::SAMPLE_W-1:0]    adc_data,
  input  wire logic [ccd_seq_pkg::TEMP_W-1:0]        sensor_temp,
  input  wire logic                                  temp_read_req,
  input  wire logic                                  setpoint_wr,
  input  wire logic [ccd_seq_pkg::TEMP_W-1:0]        setpoint_in,
  input  wire logic                                  regulation_stable,
  output logic                                       parallel_shift,
  output logic                                       serial_shift,
  output logic                                       clean_shift,
  output logic [3:0]                                 adc_convert,
  output logic                                       single_port_mode,
  output logic                                       busy,
  output logic                                       ready,
  output logic [ccd_seq_pkg::SAMPLE_W-1:0]           pix_data,
  output logic [1:0]                                 pix_port,
  output logic                                       pix_valid,
  output logic                                       frame_done,
  output logic [ccd_seq_pkg::TEMP_W-1:0]             temp_value,
  output logic                                       temp_valid,
  output logic [ccd_seq_pkg::TEMP_W-1:0]             setpoint,
  output logic                                       temp_locked
);
  localparam int HALF_ROWS = ROWS / 2;
  localparam int HALF_COLS = COLS / 2;
  localparam int CW = ccd_seq_pkg::COORD_W;
  localparam int SW = ccd_seq_pkg::SAMPLE_W;

  typedef enum logic [1:0] {CLEANING, ROW_SHIFT, SER_SHIFT, DRAIN} state_t;

  state_t             state_reg, state_next;
  logic [CW-1:0]      row_reg, row_next;    // row transfers so far (row pairs in four-port mode)
  logic [CW-1:0]      col_reg, col_next;    // serial positions emptied
  logic               single_reg, single_next;
  logic [1:0]         clean_cnt_reg, clean_cnt_next;
  logic [SW-1:0]      pix_data_next;
  logic [1:0]         pix_port_next;
  logic               pix_valid_next, frame_done_next;
  logic               roi_centered, row_last, col_last;
  logic [CW-1:0]      ser_len, cur_x, cur_y;
  logic [CW-1:0]      sp_x, sp_y, px, py;
  logic [3:0]         port_hit;
  // one host port for four converters: samples of a shift wait here
  logic [4*SW-1:0]    hold_reg, hold_next;
  logic [3:0]         pend_reg, pend_next;  // ports still to deliver
  logic [3:0]         avail;
  logic [1:0]         pick;
  logic               slot_done;

  // centered on both axes; binned regions obey the same test
  // one bit wider so a large start plus end cannot wrap into a false match
  assign roi_centered =
    ((CW+1)'(roi_x_start) + (CW+1)'(roi_x_end) == (CW+1)'(COLS + 1)) &&
    ((CW+1)'(roi_y_start) + (CW+1)'(roi_y_end) == (CW+1)'(ROWS + 1));
  assign ser_len  = single_reg ? CW'(COLS) : CW'(HALF_COLS);
  assign row_last = (row_reg == CW'(single_reg ? ROWS - 1 : HALF_ROWS - 1));
  assign col_last = (col_reg == ser_len - CW'(1));

  // physical 1-based coordinate of the pixel just emptied at port 0
  assign cur_x = col_reg + CW'(1);
  assign cur_y = row_reg + CW'(1);
  // single-port: the whole array drains toward the factory node's corner
  assign sp_x = SINGLE_PORT[0] ? CW'(COLS) - col_reg : cur_x;
  assign sp_y = SINGLE_PORT[1] ? CW'(ROWS) - row_reg : cur_y;

  always_comb begin
    state_next      = state_reg;
    row_next        = row_reg;
    col_next        = col_reg;
    single_next     = single_reg;
    clean_cnt_next  = clean_cnt_reg + 2'h1;
    hold_next       = hold_reg;
    pend_next       = pend_reg;
    pix_data_next   = pix_data;
    pix_port_next   = pix_port;
    pix_valid_next  = 1'b0;
    frame_done_next = 1'b0;
    parallel_shift  = 1'b0;
    serial_shift    = 1'b0;
    clean_shift     = 1'b0;
    adc_convert     = 4'h0;
    port_hit        = 4'h0;
    avail           = 4'h0;
    pick            = 2'h0;
    px              = '0;
    py              = '0;
    slot_done       = 1'b0;
    case (state_reg)
      CLEANING: begin
        clean_shift = (clean_cnt_reg == 2'(ccd_seq_pkg::CLEAN_DIV - 1));
        if (exposure_end) begin
          single_next = !(full_frame || roi_centered);
          row_next    = '0;
          col_next    = '0;
          state_next  = ROW_SHIFT;
        end
      end
      ROW_SHIFT: begin
        parallel_shift = 1'b1;
        col_next       = '0;
        state_next     = SER_SHIFT;
      end
      SER_SHIFT: begin
        serial_shift = 1'b1;
        // every pixel converted when emptied, even outside the region
        adc_convert  = single_reg ? (4'h1 << SINGLE_PORT) : 4'hF;
        hold_next    = adc_data;
        for (int p = 0; p < 4; p++) begin
          px = p[0] ? CW'(COLS) - col_reg : cur_x;
          py = p[1] ? CW'(ROWS) - row_reg : cur_y;
          if (single_reg) begin
            px = sp_x;
            py = sp_y;
          end
          port_hit[p] = adc_convert[p] &&
                        (full_frame || (px >= roi_x_start && px <= roi_x_end &&
                                        py >= roi_y_start && py <= roi_y_end));
        end
        avail = port_hit;
      end
      DRAIN: begin
        avail = pend_reg;
      end
      default: state_next = CLEANING;
    endcase
    // one host sample per cycle, lowest port first; the others wait in hold_reg
    for (int p = 3; p >= 0; p--) begin
      if (avail[p]) begin
        pick = 2'(p);
      end
    end
    if (avail != 4'h0) begin
      pix_data_next  = (state_reg == DRAIN) ? hold_reg[pick*SW +: SW]
                                            : adc_data[pick*SW +: SW];
      pix_port_next  = pick;
      pix_valid_next = 1'b1;
    end
    pend_next = avail & ~(4'h1 << pick);
    slot_done = (state_reg == SER_SHIFT || state_reg == DRAIN) && (pend_next == 4'h0);
    if (state_reg == SER_SHIFT && !slot_done) begin
      state_next = DRAIN;
    end
    // next shift waits until every kept sample has left: slower, but lossless
    if (slot_done) begin
      col_next = col_reg + CW'(1);
      if (col_last) begin
        if (row_last) begin
          frame_done_next = 1'b1;
          state_next      = CLEANING;
        end else begin
          row_next   = row_reg + CW'(1);
          state_next = ROW_SHIFT;
        end
      end else begin
        state_next = SER_SHIFT;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= CLEANING;
      row_reg       <= '0;
      col_reg       <= '0;
      single_reg    <= 1'b0;
      clean_cnt_reg <= 2'h0;
      pix_data      <= ccd_seq_pkg::SAMPLE_RST;
      pix_port      <= 2'h0;
      pix_valid     <= 1'b0;
      frame_done    <= 1'b0;
      hold_reg      <= '0;
      pend_reg      <= 4'h0;
    end else begin
      state_reg     <= state_next;
      row_reg       <= row_next;
      col_reg       <= col_next;
      single_reg    <= single_next;
      clean_cnt_reg <= clean_cnt_next;
      pix_data      <= pix_data_next;
      pix_port      <= pix_port_next;
      pix_valid     <= pix_valid_next;
      frame_done    <= frame_done_next;
      hold_reg      <= hold_next;
      pend_reg      <= pend_next;
    end
  end

  assign single_port_mode = single_reg;
  assign busy             = (state_reg != CLEANING);
  assign ready            = (state_reg == CLEANING);

  // temperature side
  logic [ccd_seq_pkg::TEMP_W-1:0] temp_next, setpoint_next;
  logic                           temp_valid_next, locked_next;

  always_comb begin
    temp_next       = temp_value;
    temp_valid_next = 1'b0;
    setpoint_next   = setpoint;
    locked_next     = regulation_stable;
    if (temp_read_req) begin
      temp_next       = sensor_temp;
      temp_valid_next = 1'b1;
    end
    if (setpoint_wr) begin
      setpoint_next = setpoint_in;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_value  <= ccd_seq_pkg::TEMP_RST;
      temp_valid  <= 1'b0;
      setpoint    <= ccd_seq_pkg::TEMP_RST;
      temp_locked <= 1'b0;
    end else begin
      temp_value  <= temp_next;
      temp_valid  <= temp_valid_next;
      setpoint    <= setpoint_next;
      temp_locked <= locked_next;
    end
  end
endmodule

//--- hw/ccd_seq_pkg.sv
/*
  Shared constants for the sensor readout sequencer: array geometry,
  sample widths and cycle counts. Assumes a single 100 MHz clock.
*/
package ccd_seq_pkg;
  localparam int COLS         = 16;   // pixels per row (even)
  localparam int ROWS         = 16;   // rows in whole array (even)
  localparam int COORD_W      = 13;
  localparam int SAMPLE_W     = 16;
  localparam int TEMP_W       = 12;
  localparam int CLEAN_DIV    = 4;    // cycles between cleaning shifts
  localparam logic [1:0] SINGLE_PORT_DEFAULT = 2'h0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
  localparam logic [TEMP_W-1:0]   TEMP_RST   = 12'h000;
endpackage

//--- bench/adc_model.sv
/* Converter model at the sensor side.
   Assumes adc_convert strobes come from the sequencer. */
`timescale 1ns/1ns
module adc_model (
  input  wire logic        clk,
  input  wire logic [3:0]  adc_convert,
  output logic      [63:0] adc_data
);
  logic [11:0] cnt_reg = 12'h000;
  always_ff @(posedge clk) if (adc_convert != 4'h0) cnt_reg <= cnt_reg + 12'h001;
  // port in top nibble; inverted when idle so stale data never looks valid
  always_comb for (int p = 0; p < 4; p++)
    adc_data[p*16+:16] = adc_convert[p] ? {4'(p), cnt_reg} : ~{4'(p), cnt_reg};
endmodule

//--- bench/ccd_seq_props.sv
/* Port checker for the readout sequencer.
   Assumes it is bound into every sequencer instance. */
`timescale 1ns/1ns
module ccd_seq_props #(parameter int COLS = 16, parameter int ROWS = 16,
  parameter logic [1:0] SINGLE_PORT = 2'h0) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        exposure_end,
  input wire logic        full_frame,
  input wire logic [12:0] roi_x_start,
  input wire logic [12:0] roi_x_end,
  input wire logic [12:0] roi_y_start,
  input wire logic [12:0] roi_y_end,
  input wire logic [11:0] sensor_temp,
  input wire logic        temp_read_req,
  input wire logic        regulation_stable,
  input wire logic        parallel_shift,
  input wire logic        serial_shift,
  input wire logic [3:0]  adc_convert,
  input wire logic        single_port_mode,
  input wire logic        ready,
  input wire logic [11:0] temp_value,
  input wire logic        temp_valid,
  input wire logic        temp_locked,
  input wire logic        clean_shift,
  input wire logic        pix_valid,
  input wire logic        frame_done
);
  logic [15:0] ser_cnt;
  logic        in_row;
  // serial shifts since the last row transfer of the running frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_cnt <= 16'h0000;
      in_row  <= 1'b0;
    end else if (parallel_shift) begin
      ser_cnt <= 16'h0000;
      in_row  <= 1'b1;
    end else if (frame_done) begin
      ser_cnt <= 16'h0000;
      in_row  <= 1'b0;
    end else if (serial_shift) begin
      ser_cnt <= ser_cnt + 16'h0001;
    end
  end
  wire logic cen = (14'(roi_x_start) + roi_x_end == 14'(COLS + 1)) &&
                   (14'(roi_y_start) + roi_y_end == 14'(ROWS + 1));
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  start_shift_a: assert property (ready && exposure_end |=> parallel_shift && !ready)
    else $error("no row shift");
  row_drain_a: assert property ((parallel_shift || frame_done) && in_row |->
    ser_cnt == 16'(single_port_mode ? COLS : COLS / 2)) else $error("row drain");
  shift_follow_a: assert property (parallel_shift |=> serial_shift)
    else $error("no serial shift after row transfer");
  clean_idle_a: assert property (clean_shift |-> ready)
    else $error("cleaning shift while reading out");
  convert_a: assert property (serial_shift == (adc_convert != 4'h0))
    else $error("convert");
  quad_port_a: assert property (serial_shift && !single_port_mode |-> adc_convert == 4'hF)
    else $error("four port");
  one_port_a: assert property (serial_shift && single_port_mode |->
    adc_convert == (4'h1 << SINGLE_PORT)) else $error("one port");
  port_choice_a: assert property (ready && exposure_end |=>
    single_port_mode != ($past(full_frame) || $past(cen))) else $error("port choice");
  temp_read_a: assert property (temp_read_req |=>
    temp_valid && temp_value == $past(sensor_temp)) else $error("temp read");
  lock_follow_a: assert property (1'b1 |=> temp_locked == $past(regulation_stable))
    else $error("lock");
  cover property (serial_shift && single_port_mode);
  cover property (serial_shift && !single_port_mode);
  cover property (temp_valid);
  cover property (frame_done && single_port_mode);
endmodule
bind ccd_readout_seq ccd_seq_props #(.COLS(COLS), .ROWS(ROWS), .SINGLE_PORT(SINGLE_PORT))
  chk (.*);

//--- bench/tb_top.sv
/* Self-checking bench for the readout sequencer.
   Assumes adc_model as converters and the bound checker. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top;
  localparam logic [1:0] SP = ccd_seq_pkg::SINGLE_PORT_DEFAULT;
  logic        clk = 1'b0, arst_n = 1'b0, exposure_end = 1'b0, full_frame = 1'b0;
  logic        binning_en = 1'b0, temp_read_req = 1'b0, setpoint_wr = 1'b0;
  logic        regulation_stable = 1'b0, parallel_shift, serial_shift, clean_shift, busy;
  logic        single_port_mode, ready, pix_valid, frame_done, temp_valid, temp_locked;
  logic [12:0] roi_x_start = 13'h0001, roi_x_end = 13'h0010;
  logic [12:0] roi_y_start = 13'h0001, roi_y_end = 13'h0010;
  logic [11:0] sensor_temp = 12'h000, setpoint_in = 12'h000, temp_value, setpoint;
  logic [63:0] adc_data;
  logic [15:0] pix_data;
  logic [3:0]  adc_convert;
  logic [1:0]  pix_port;
  int          miscompares = 0, cmp_count = 0;
  ccd_readout_seq #(.SINGLE_PORT(SP)) DUT (.*);
  adc_model conv (.*);
  initial forever #5 clk = ~clk;
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic ff, bn, input logic [12:0] xs, xe, ys, ye,
                       input int np, ns, npx, input logic md);
    int par, ser, pix, cln, k;
    par = 0;
    cln = 0;
    ser = 0;
    pix = 0;
    repeat (6) @(posedge clk);
    #1;
    {full_frame, binning_en, roi_x_start, roi_x_end, roi_y_start, roi_y_end} =
      {ff, bn, xs, xe, ys, ye};
    exposure_end = 1'b1;
    for (k = 0; k < 3000 && frame_done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      // held over two busy edges, which must not restart the frame
      if (k == 2) exposure_end = 1'b0;
      if (k == 0) `CHK("busy", 1'b1, busy)
      par += int'(parallel_shift);
      ser += int'(serial_shift);
      if (pix_valid === 1'b1) begin
        pix++;
        `CHK("sample port", {2'h0, pix_port}, pix_data[15:12])
        if (md) `CHK("single port", SP, pix_port)
      end
    end
    if (k == 3000) begin miscompares++; wrap_up(); end
    `CHK("row shifts", np, par)
    `CHK("serial shifts", ns, ser)
    `CHK("samples", npx, pix)
    `CHK("mode", md, single_port_mode)
    `CHK("ready", 1'b1, ready)
    `CHK("idle", 1'b0, busy)
    repeat (8) begin
      @(posedge clk);
      #1;
      cln += int'(clean_shift);
    end
    `CHK("cleaning", 8 / ccd_seq_pkg::CLEAN_DIV, cln)
  endtask
  task automatic full_scn;
    frame(1'b1, 1'b0, 13'h0001, 13'h0010, 13'h0001, 13'h0010, 8, 64, 256, 1'b0);
  endtask
  task automatic roi_scn;
    for (int b = 0; b < 2; b++) begin
      frame(1'b0, b[0], 13'h0005, 13'h000C, 13'h0007, 13'h000A, 8, 64, 32, 1'b0);
      frame(1'b0, b[0], 13'h0001, 13'h0004, 13'h0001, 13'h0002, 16, 256, 8, 1'b1);
    end
  endtask
  task automatic temp_scn;
    {sensor_temp, setpoint_in, temp_read_req, setpoint_wr} = {12'hA5C, 12'h3C1, 2'h3};
    regulation_stable = 1'b1;
    @(posedge clk);
    #1;
    {temp_read_req, setpoint_wr, regulation_stable} = 3'h0;
    `CHK("temp value", 12'hA5C, temp_value)
    `CHK("temp valid", 1'b1, temp_valid)
    `CHK("setpoint", 12'h3C1, setpoint)
    `CHK("lock set", 1'b1, temp_locked)
    @(posedge clk);
    #1;
    `CHK("lock lost", 1'b0, temp_locked)
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    `CHK("ready after reset", 1'b1, ready)
    full_scn();
    roi_scn();
    temp_scn();
    wrap_up();
  end
endmodule
